// [design/spirm_pkg.sv]
// spirm_pkg: register map, field layouts, reset values and helpers of the spi block
// assumes the bus fabric selects the block inside its 4 KiB window at the base below
package spirm_pkg;

  // block base; offsets are byte addresses inside the window
  localparam logic [31:0] BASE_ADDR = 32'h4040_0000;
  localparam logic [11:0] OFS_CTRL0 = 12'h000;
  localparam logic [11:0] OFS_CTRL1 = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;
  localparam logic [11:0] OFS_PRESC = 12'h010;
  localparam logic [11:0] OFS_IMASK = 12'h014;
  localparam logic [11:0] OFS_RAW = 12'h018;
  localparam logic [11:0] OFS_MIS = 12'h01C;
  localparam logic [11:0] OFS_ICLR = 12'h020;
  localparam logic [11:0] OFS_DMA = 12'h024;
  localparam logic [11:0] OFS_RXCNT = 12'h028;
  localparam logic [11:0] OFS_DUMMY = 12'h02C;
  localparam logic [11:0] OFS_TXCNT = 12'h030;
  localparam logic [11:0] OFS_INTEGRATION_TEST_CTRL = 12'h080;
  localparam logic [11:0] OFS_TDATA = 12'h08C;

  // values after reset
  localparam logic [31:0] CTRL0_RST = 32'h1C00_0000;
  localparam logic [31:0] STAT_RST = 32'h0000_0003;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

  // status bit positions
  localparam int STB_TX_EMPTY = 0;
  localparam int STB_TX_NFULL = 1;
  localparam int STB_RX_NEMPTY = 2;
  localparam int STB_RX_FULL = 3;
  localparam int STB_BUSY = 4;

  // interrupt source positions
  localparam int IRQ_W = 3;
  localparam int IRQ_OVERRUN = 0;
  localparam int IRQ_RX_AVAIL = 1;
  localparam int IRQ_TX_EMPTY = 2;

  // dma enable positions
  localparam int DMA_W = 2;
  localparam int DMA_RX = 0;
  localparam int DMA_TX = 1;

  // frame lengths in bits, and the three-wire format code
  localparam logic [5:0] MIN_FRAME = 6'h04;
  localparam logic [5:0] FULL_WORD = 6'h20;
  localparam logic [1:0] FMT_THREE = 2'h2;

  typedef enum logic [1:0] {
    SPIRM_DUPLEX = 2'h0,
    SPIRM_TX_ONLY = 2'h1,
    SPIRM_RX_DUMMY = 2'h2,
    SPIRM_COMBINED = 2'h3
  } spirm_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } spirm_state_t;

  // control_primary layout, msb first
  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic cs1;
    logic rsvd25;
    spirm_mode_t master_mode;
    logic [1:0] frame_format_select;
    logic [4:0] cmd_bits_select;
    logic [7:0] serial_rate_factor;
    logic clock_phase_select;
    logic clock_idle_level;
    logic rsvd5;
    logic [4:0] frame_bits_select;
  } spirm_ctrl0_t;

  // control_secondary layout, msb first
  typedef struct packed {
    logic [25:0] rsvd_hi;
    logic [1:0] rx_endian;
    logic slave_out_dis;
    logic slave_mode;
    logic enable;
    logic rsvd0;
  } spirm_ctrl1_t;

  // serial link outputs
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic mosi_oe_n;
    logic cs_n;
  } spirm_pins_t;

  // field value plus one; reserved codes fall back to the shortest frame
  function automatic logic [5:0] frame_len(input logic [4:0] field);
    logic [5:0] n;
    n = {1'b0, field} + 6'h01;
    return (n < MIN_FRAME) ? MIN_FRAME : n;
  endfunction

  // move an n-bit word up to bit 31 so it leaves msb first
  function automatic logic [31:0] align_msb(input logic [31:0] w, input logic [5:0] n);
    return w << (FULL_WORD - n);
  endfunction

  // low n bits set
  function automatic logic [31:0] low_mask(input logic [5:0] n);
    return (n >= FULL_WORD) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
  endfunction

  // half a bit period: divisor/2 * (1 + rate); a zero divisor runs at the fastest pace
  function automatic logic [14:0] half_period(input logic [7:0] presc, input logic [7:0] rate);
    logic [15:0] p;
    p = {9'h000, presc[7:1]} * ({8'h00, rate} + 16'h0001);
    return (p == 16'h0000) ? 15'h0001 : p[14:0];
  endfunction

endpackage

// [design/spirm_fifo.sv]
// spirm_fifo: small first-in first-out store for serial frames
// assumes one clock; read data always show the current head from a register
`timescale 1ns/100ps
`default_nettype none
module spirm_fifo #(
  parameter int W = 32,
  parameter int AW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic empty,
  output logic full
);
  logic [W-1:0] mem [2**AW]; // storage, no reset needed
  logic [AW:0] wptr, rptr; // extra bit tells full from empty
  logic [AW:0] next_wptr, next_rptr;
  logic [W-1:0] next_rdata;
  logic do_push, do_pop;

  // pointer step and head lookahead
  always_comb begin
    empty = (wptr == rptr);
    full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
    do_push = push & ~full; // pushes into a full store are dropped
    do_pop = pop & ~empty;
    next_wptr = wptr + {{AW{1'b0}}, do_push};
    next_rptr = rptr + {{AW{1'b0}}, do_pop};
    // bypass so a word written to the new head is seen at once
    if (do_push && (wptr[AW-1:0] == next_rptr[AW-1:0])) begin
      next_rdata = wdata;
    end else begin
      next_rdata = mem[next_rptr[AW-1:0]];
    end
  end

  // pointers and head register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= '0;
      rptr <= '0;
      rdata <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      rdata <= next_rdata;
    end
  end

  // storage write
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wptr[AW-1:0]] <= wdata;
    end
  end
endmodule // spirm_fifo
`default_nettype wire

// [design/spirm_rate.sv]
// spirm_rate: half bit period pacer for the serial clock
// assumes run rises at frame launch; first tick comes one half period later
`timescale 1ns/100ps
`default_nettype none
module spirm_rate #(
  parameter int CW = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [CW-1:0] half,
  output logic tick
);
  logic [CW-1:0] cnt; // cycles into the current half period
  logic [CW-1:0] next_cnt;

  // count up to half-1, restart at each tick
  always_comb begin
    tick = run && (cnt == half - {{(CW-1){1'b0}}, 1'b1});
    next_cnt = (!run || tick) ? '0 : cnt + {{(CW-1){1'b0}}, 1'b1};
  end

  // counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule // spirm_rate
`default_nettype wire

// [design/spirm_top.sv]
// spirm_top: apb register file and serial master engine of the spi block
// assumes an apb3 master, one clock, miso tied to mosi outside in three-wire use
// Functional notes
// - block sits at a fixed base address
// - control_primary at 0x00, resets 0x1C000000
// - status_flags read-only, reads 0x3 after reset
// - frame length is field value plus one
// - bit 6 sets serial clock idle level
// - bit 7 selects serial clock phase
// - bit rate is clock/(divisor*(1+factor))
// - interrupt_mask gates raw sources to output
// - raw and masked interrupt state read-only
// - interrupt_clear write-only, clears overrun bit where written one
// - dma_request_ctrl enables fifo dma requests
// - receive_frame_count register, resets zero
// - tx_fifo_frame_count register, resets zero
// - data port reads and writes fifos
// - test control and test data registers
// - format zero four-wire, two three-wire
// - writing one clears overrun interrupt
// - dummy sends decrement receive count first
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module spirm_top #(
  parameter int FIFO_AW = 3,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic miso,
  output spirm_pkg::spirm_pins_t link,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  import spirm_pkg::*;

  // bus side state
  logic ack_q, next_ack; // one wait state, then ready
  logic [31:0] next_prdata;
  logic [11:0] ofs; // offset inside the window
  logic in_blk, mapped, wr_go, rd_go;
  logic [31:0] rd_word;

  // software visible registers
  spirm_ctrl0_t ctrl0, next_ctrl0;
  spirm_ctrl1_t ctrl1, next_ctrl1;
  logic [7:0] presc, next_presc; // even 2..254 expected
  logic [IRQ_W-1:0] imask, next_imask;
  logic [DMA_W-1:0] dma, next_dma;
  logic [CNT_W-1:0] rxcnt, next_rxcnt;
  logic [CNT_W-1:0] txcnt, next_txcnt;
  logic [31:0] dummy, next_dummy;
  logic [31:0] integration_test_ctrl, next_integration_test_ctrl;
  logic [31:0] tdata, next_tdata;
  logic ovr, next_ovr; // sticky receive overrun
  logic [IRQ_W-1:0] raw, masked;
  logic [31:0] stat_word;

  // fifo ports
  logic tx_push, tx_pop, tx_empty, tx_full;
  logic rx_push, rx_pop, rx_empty, rx_full;
  logic [31:0] tx_rdata, rx_rdata, rx_wdata;

  // engine state
  spirm_state_t state, next_state;
  logic [31:0] shreg, next_shreg; // msb leaves first
  logic [6:0] bitc, next_bitc; // trailing edges so far, up to 64 in three-wire
  logic [6:0] total, next_total; // bits in this frame; seven bits so 32 + 32 fits
  logic [5:0] cmdn, next_cmdn; // bits driven out
  logic [5:0] rxn, next_rxn; // bits kept on receive
  logic phase, next_phase; // 0 before leading edge
  logic capt, next_capt; // leading edge sample
  logic sclk_q, next_sclk;
  logic mosi_q, next_mosi;
  logic drun, next_drun; // dummy run under way
  logic tick, go_ok, send_tx, send_dum, rx_dec, tx_dec, ovr_evt;
  logic fmt3, cpol, cpha, keep_rx;
  logic [5:0] data_n, cmd_n;
  logic [31:0] ld_word;
  logic [14:0] half;

  // apb decode; one fixed wait state keeps the fifo head settled
  always_comb begin
    ofs = paddr[11:0];
    in_blk = (paddr[31:12] == BASE_ADDR[31:12]);
    pready = psel & penable & ack_q;
    next_ack = psel & penable & ~ack_q;
    wr_go = pready & pwrite & in_blk;
    rd_go = pready & ~pwrite & in_blk;
    pslverr = pready & ~(in_blk & mapped);
    tx_push = wr_go && (ofs == OFS_DATA);
    rx_pop = rd_go && (ofs == OFS_DATA);
  end

  // status and interrupt views
  always_comb begin
    stat_word = ZERO_RST;
    stat_word[STB_TX_EMPTY] = tx_empty;
    stat_word[STB_TX_NFULL] = ~tx_full;
    stat_word[STB_RX_NEMPTY] = ~rx_empty;
    stat_word[STB_RX_FULL] = rx_full;
    stat_word[STB_BUSY] = (state != ST_IDLE);
    raw = '0;
    raw[IRQ_OVERRUN] = ovr;
    raw[IRQ_RX_AVAIL] = ~rx_empty;
    raw[IRQ_TX_EMPTY] = tx_empty & ctrl1.enable; // quiet until enabled, so raw resets to zero
    masked = raw & imask;
    irq = |masked;
    tx_dma_req = dma[DMA_TX] & ~tx_full;
    rx_dma_req = dma[DMA_RX] & ~rx_empty;
  end

  // read mux; write-only clear reads as zero
  always_comb begin
    rd_word = ZERO_RST;
    mapped = 1'b1;
    case (ofs)
      OFS_CTRL0: rd_word = ctrl0;
      OFS_CTRL1: rd_word = ctrl1;
      OFS_DATA: rd_word = rx_empty ? ZERO_RST : rx_rdata;
      OFS_STAT: rd_word = stat_word;
      OFS_PRESC: rd_word = {24'h000000, presc};
      OFS_IMASK: rd_word = {{(32-IRQ_W){1'b0}}, imask};
      OFS_RAW: rd_word = {{(32-IRQ_W){1'b0}}, raw};
      OFS_MIS: rd_word = {{(32-IRQ_W){1'b0}}, masked};
      OFS_ICLR: rd_word = ZERO_RST;
      OFS_DMA: rd_word = {{(32-DMA_W){1'b0}}, dma};
      OFS_RXCNT: rd_word = 32'(rxcnt);
      OFS_DUMMY: rd_word = dummy;
      OFS_TXCNT: rd_word = 32'(txcnt);
      OFS_INTEGRATION_TEST_CTRL: rd_word = integration_test_ctrl;
      OFS_TDATA: rd_word = tdata;
      default: mapped = 1'b0; // unmapped reads zero, flags pslverr
    endcase
    // captured on the first access cycle, held to the ready cycle
    next_prdata = (psel & penable & ~ack_q & ~pwrite) ? (in_blk ? rd_word : ZERO_RST) : prdata;
  end

  // register next values; software write wins over a same-cycle decrement
  always_comb begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    next_presc = presc;
    next_imask = imask;
    next_dma = dma;
    next_dummy = dummy;
    next_integration_test_ctrl = integration_test_ctrl;
    next_tdata = tdata;
    next_rxcnt = rx_dec ? rxcnt - {{(CNT_W-1){1'b0}}, 1'b1} : rxcnt;
    next_txcnt = tx_dec ? txcnt - {{(CNT_W-1){1'b0}}, 1'b1} : txcnt;
    // set wins over clear so an overrun in the clear cycle stays
    next_ovr = ovr | ovr_evt;
    if (wr_go) begin
      case (ofs)
        OFS_CTRL0: next_ctrl0 = spirm_ctrl0_t'(pwdata);
        OFS_CTRL1: next_ctrl1 = spirm_ctrl1_t'(pwdata);
        OFS_PRESC: next_presc = pwdata[7:0];
        OFS_IMASK: next_imask = pwdata[IRQ_W-1:0];
        OFS_ICLR: next_ovr = (ovr & ~pwdata[IRQ_OVERRUN]) | ovr_evt;
        OFS_DMA: next_dma = pwdata[DMA_W-1:0];
        OFS_RXCNT: next_rxcnt = pwdata[CNT_W-1:0];
        OFS_DUMMY: next_dummy = pwdata;
        OFS_TXCNT: next_txcnt = pwdata[CNT_W-1:0];
        OFS_INTEGRATION_TEST_CTRL: next_integration_test_ctrl = pwdata;
        OFS_TDATA: next_tdata = pwdata;
        default: ;
      endcase
    end
  end

  // bus and register flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      prdata <= ZERO_RST;
      ctrl0 <= spirm_ctrl0_t'(CTRL0_RST);
      ctrl1 <= spirm_ctrl1_t'(ZERO_RST);
      presc <= ZERO_RST[7:0];
      imask <= ZERO_RST[IRQ_W-1:0];
      dma <= ZERO_RST[DMA_W-1:0];
      rxcnt <= ZERO_RST[CNT_W-1:0];
      txcnt <= ZERO_RST[CNT_W-1:0];
      dummy <= ZERO_RST;
      integration_test_ctrl <= ZERO_RST;
      tdata <= ZERO_RST;
      ovr <= 1'b0;
    end else begin
      ack_q <= next_ack;
      prdata <= next_prdata;
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      presc <= next_presc;
      imask <= next_imask;
      dma <= next_dma;
      rxcnt <= next_rxcnt;
      txcnt <= next_txcnt;
      dummy <= next_dummy;
      integration_test_ctrl <= next_integration_test_ctrl;
      tdata <= next_tdata;
      ovr <= next_ovr;
    end
  end

  // frame stores behind the data port
  spirm_fifo #(.W(32), .AW(FIFO_AW)) u_txf (
    .pclk(pclk), .presetn(presetn), .push(tx_push), .wdata(pwdata),
    .pop(tx_pop), .rdata(tx_rdata), .empty(tx_empty), .full(tx_full));
  spirm_fifo #(.W(32), .AW(FIFO_AW)) u_rxf (
    .pclk(pclk), .presetn(presetn), .push(rx_push), .wdata(rx_wdata),
    .pop(rx_pop), .rdata(rx_rdata), .empty(rx_empty), .full(rx_full));

  // half bit pacer
  spirm_rate #(.CW(15)) u_rate (
    .pclk(pclk), .presetn(presetn), .run(state == ST_RUN), .half(half), .tick(tick));

  // launch decision; a mode change also counts for the frame under way, as keep_rx is read when it ends
  always_comb begin
    fmt3 = (ctrl0.frame_format_select == FMT_THREE);
    cpol = ~fmt3 & ctrl0.clock_idle_level;
    cpha = ~fmt3 & ctrl0.clock_phase_select;
    data_n = frame_len(ctrl0.frame_bits_select);
    cmd_n = frame_len(ctrl0.cmd_bits_select);
    half = half_period(presc, ctrl0.serial_rate_factor);
    keep_rx = fmt3 | (ctrl0.master_mode != SPIRM_TX_ONLY);
    go_ok = ctrl1.enable & ~ctrl1.slave_mode; // master only
    send_tx = ~tx_empty;
    send_dum = 1'b0;
    if (!fmt3) begin
      unique case (ctrl0.master_mode)
        SPIRM_DUPLEX, SPIRM_TX_ONLY: send_tx = ~tx_empty;
        SPIRM_RX_DUMMY: begin
          // once dummies start, queued words wait until the count runs out
          send_tx = ~tx_empty & ~drun;
          send_dum = ~send_tx & (rxcnt != '0);
        end
        SPIRM_COMBINED: begin
          send_tx = ~tx_empty & (txcnt != '0) & ~drun;
          send_dum = (txcnt == '0) & (rxcnt != '0);
        end
      endcase
    end
    ld_word = send_tx ? tx_rdata : dummy;
  end

  // serial engine next state
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitc = bitc;
    next_total = total;
    next_cmdn = cmdn;
    next_rxn = rxn;
    next_phase = phase;
    next_capt = capt;
    next_sclk = sclk_q;
    next_mosi = mosi_q;
    next_drun = drun & (rxcnt != '0);
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_dec = 1'b0;
    tx_dec = 1'b0;
    ovr_evt = 1'b0;
    rx_wdata = shreg & low_mask(rxn);
    unique case (state)
      ST_IDLE: begin
        next_sclk = cpol;
        if (go_ok && (send_tx || send_dum)) begin
          // three-wire: command bits out, then data bits in
          next_cmdn = fmt3 ? cmd_n : data_n;
          next_rxn = data_n;
          next_total = fmt3 ? {1'b0, cmd_n} + {1'b0, data_n} : {1'b0, data_n};
          next_shreg = align_msb(ld_word, next_cmdn);
          next_mosi = next_shreg[31];
          next_bitc = '0;
          next_phase = 1'b0;
          tx_pop = send_tx;
          rx_dec = send_dum;
          tx_dec = send_tx & ~fmt3 & (ctrl0.master_mode == SPIRM_COMBINED);
          if (send_dum) begin
            next_drun = (rxcnt != {{(CNT_W-1){1'b0}}, 1'b1});
          end
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tick) begin
          next_phase = ~phase;
          if (!phase) begin
            // leading edge
            next_sclk = ~cpol;
            if (!cpha) begin
              next_capt = miso;
            end else begin
              next_mosi = shreg[31];
            end
          end else begin
            // trailing edge: shift in, count the bit
            next_sclk = cpol;
            next_shreg = {shreg[30:0], cpha ? miso : capt};
            next_bitc = bitc + 7'h01;
            if (!cpha) begin
              next_mosi = shreg[30];
            end
            if (bitc + 7'h01 == total) begin
              next_state = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
        if (keep_rx) begin
          // a full store keeps its words; the new frame is lost
          ovr_evt = rx_full;
          rx_push = ~rx_full;
        end
      end
      default: next_state = ST_IDLE; // recover from an illegal code
    endcase
  end

  // serial engine flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      shreg <= ZERO_RST;
      bitc <= '0;
      total <= {1'b0, MIN_FRAME};
      cmdn <= MIN_FRAME;
      rxn <= MIN_FRAME;
      phase <= 1'b0;
      capt <= 1'b0;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      drun <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitc <= next_bitc;
      total <= next_total;
      cmdn <= next_cmdn;
      rxn <= next_rxn;
      phase <= next_phase;
      capt <= next_capt;
      sclk_q <= next_sclk;
      mosi_q <= next_mosi;
      drun <= next_drun;
    end
  end

  // pins; three-wire releases the line once the command is out
  always_comb begin
    link.sclk = sclk_q;
    link.mosi = mosi_q;
    link.mosi_oe_n = fmt3 & ~((state == ST_RUN) && (bitc < {1'b0, cmdn}));
    link.cs_n = ctrl0.cs1;
  end

  // checking helpers: first cycle out of reset, cycles in a half period
  logic first_q;
  logic [14:0] since_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b1;
      since_q <= '0;
    end else begin
      first_q <= 1'b0;
      since_q <= ((state != ST_RUN) || tick) ? '0 : since_q + 15'h0001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ctrl_reset: assert property (first_q |-> ctrl0 == CTRL0_RST)
    else $error("control_primary not at reset value");
  a_status_reset: assert property (first_q |-> stat_word == STAT_RST)
    else $error("status_flags not at reset value");
  a_frame_len: assert property (
    state == ST_DONE |-> bitc == total && total >= {1'b0, MIN_FRAME})
    else $error("frame ended at wrong bit count");
  a_idle_level: assert property (
    state == ST_IDLE && $past(state) == ST_IDLE && $stable(cpol) |-> link.sclk == cpol)
    else $error("idle clock level wrong");
  a_phase_edge: assert property (
    state == ST_RUN && $past(state) == ST_RUN && $changed(link.mosi)
      |-> link.sclk == (cpol ^ cpha))
    else $error("data changed on wrong clock edge");
  a_half_rate: assert property (tick |-> since_q == half - 15'h0001)
    else $error("half period length wrong");
  a_mask_read: assert property (
    rd_go && ofs == OFS_MIS |-> prdata == {29'h0, $past(raw & imask)})
    else $error("masked status read wrong");
  a_clear_ovr: assert property (
    wr_go && ofs == OFS_ICLR && pwdata[IRQ_OVERRUN] && !ovr_evt |=> !ovr)
    else $error("overrun not cleared");
  a_rx_dec: assert property (
    rx_dec && !(wr_go && ofs == OFS_RXCNT) |=> rxcnt == $past(rxcnt) - 1'b1 && state == ST_RUN)
    else $error("receive count not decremented at launch");
  a_tx_dec: assert property (
    tx_dec && !(wr_go && ofs == OFS_TXCNT) ##1 1'b1 |-> txcnt == $past(txcnt) - 1'b1)
    else $error("transmit count not decremented at launch");
endmodule // spirm_top
`default_nettype wire

// [tb/spirm_slave.sv]
// spirm_slave: far-side serial slave that answers with a fixed pattern
// assumes the clock idles low and the master samples on the rising edge
`timescale 1ns/100ps
`default_nettype none
module spirm_slave (
  input wire spirm_pkg::spirm_pins_t link,
  output logic miso
);
  import spirm_pkg::*;
  // alternating bits; an even number of shifts leaves the pattern unchanged
  logic [31:0] sh = 32'hAAAA_AAAA;
  // shift on the trailing edge so the bit is steady at the next sample
  // only while selected: the clock settling at reset must not count as a shift
  always @(negedge link.sclk) begin
    if (!link.cs_n) begin
      sh <= {sh[30:0], sh[31]};
    end
  end
  // when deselected drive the inverse, so a stale bit never passes
  assign miso = link.cs_n ? ~sh[31] : sh[31];
endmodule // spirm_slave
`default_nettype wire

// [tb/spirm_top_tb.sv]
// spirm_top_tb: register map and serial frame checks of the spi block
// assumes the slave model on the link and an apb slave with one wait state
`timescale 1ns/100ps
`default_nettype none
module spirm_top_tb;
  import spirm_pkg::*;
  typedef struct packed {logic w; logic [11:0] ofs; logic [31:0] wd; logic [31:0] exp;} spirm_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, miso, irq, er, txd, rxd;
  logic [31:0] paddr, pwdata, prdata, rd, cap;
  spirm_pins_t link;
  int n_mismatch = 0, n_checks = 0, nedge = 0, n0, i;
  time t_last = 0, t_prev = 0; // times of the last two sampling edges
  // reset values first, then writes with the value read back
  spirm_row_t rows [20] = '{'{1'b0, OFS_CTRL0, ZERO_RST, CTRL0_RST},
    '{1'b0, OFS_CTRL1, ZERO_RST, ZERO_RST}, '{1'b0, OFS_DATA, ZERO_RST, ZERO_RST},
    '{1'b0, OFS_STAT, ZERO_RST, STAT_RST}, '{1'b0, OFS_PRESC, ZERO_RST, ZERO_RST},
    '{1'b0, OFS_IMASK, ZERO_RST, ZERO_RST}, '{1'b0, OFS_RAW, ZERO_RST, ZERO_RST},
    '{1'b0, OFS_MIS, ZERO_RST, ZERO_RST}, '{1'b0, OFS_ICLR, ZERO_RST, ZERO_RST},
    '{1'b0, OFS_DMA, ZERO_RST, ZERO_RST}, '{1'b0, OFS_RXCNT, ZERO_RST, ZERO_RST},
    '{1'b0, OFS_DUMMY, ZERO_RST, ZERO_RST}, '{1'b0, OFS_TXCNT, ZERO_RST, ZERO_RST},
    '{1'b0, OFS_INTEGRATION_TEST_CTRL, ZERO_RST, ZERO_RST}, '{1'b0, OFS_TDATA, ZERO_RST, ZERO_RST},
    '{1'b1, OFS_STAT, 32'hFFFF_FFFF, STAT_RST}, '{1'b1, OFS_RAW, 32'h0000_0007, ZERO_RST},
    '{1'b1, OFS_TDATA, 32'h5A5A_5A5A, 32'h5A5A_5A5A},
    '{1'b1, OFS_RXCNT, 32'hFFFF_0000, ZERO_RST}, // upper bits beyond the counter drop
    '{1'b1, OFS_DMA, 32'hFFFF_FFFF, 32'h0000_0003}};

  spirm_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .miso(miso), .link(link), .irq(irq), .tx_dma_req(txd), .rx_dma_req(rxd));
  spirm_slave u_slave (.link(link), .miso(miso));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // capture the outgoing bit and timing at each sampling edge
  always @(posedge link.sclk) begin
    cap <= {cap[30:0], link.mosi};
    nedge <= nedge + 1;
    t_prev <= t_last;
    t_last <= $time;
  end

  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] ofs, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= BASE_ADDR | {20'h00000, ofs};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    // taken at the edge that sees pready, released right after it
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] ofs, input logic [31:0] exp);
    apb(1'b0, ofs, ZERO_RST);
    chk(rd, exp);
  endtask
  // poll the busy flag, bounded
  task automatic wait_idle();
    int k;
    for (k = 0; k < 40; k++) begin
      apb(1'b0, OFS_STAT, ZERO_RST);
      if (rd[STB_BUSY] === 1'b0) break;
    end
    if (k == 40) begin
      n_mismatch++;
      final_report();
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 20; i++) begin
      if (rows[i].w) apb(1'b1, rows[i].ofs, rows[i].wd);
      rdchk(rows[i].ofs, rows[i].exp);
    end
    chk({30'h0000_0000, txd, rxd}, 32'h0000_0002);
    // four-bit frame at the fastest pace, slave selected
    apb(1'b1, OFS_PRESC, 32'h0000_0002);
    apb(1'b1, OFS_CTRL1, 32'h0000_0002);
    apb(1'b1, OFS_CTRL0, 32'h1800_0003);
    n0 = nedge;
    apb(1'b1, OFS_DATA, 32'h0000_0005);
    wait_idle();
    chk(32'(nedge - n0), 32'h0000_0004);
    chk({28'h0000000, cap[3:0]}, 32'h0000_0005);
    rdchk(OFS_RAW, 32'h0000_0006);
    apb(1'b1, OFS_IMASK, 32'h0000_0002);
    rdchk(OFS_MIS, 32'h0000_0002);
    chk({31'h00000000, irq}, 32'h0000_0001);
    rdchk(OFS_DATA, 32'h0000_000A);
    rdchk(OFS_RAW, 32'h0000_0004);
    chk({31'h00000000, irq}, ZERO_RST);
    // transmit-only mode: the answer is not kept
    apb(1'b1, OFS_CTRL0, 32'h1880_0003);
    apb(1'b1, OFS_DATA, 32'h0000_0006);
    wait_idle();
    chk({28'h0000000, cap[3:0]}, 32'h0000_0006);
    rdchk(OFS_STAT, STAT_RST);
    // dummy-character mode, rate factor 2 gives six cycles a bit
    apb(1'b1, OFS_CTRL0, 32'h1900_0203);
    apb(1'b1, OFS_DUMMY, 32'h0000_0009);
    apb(1'b1, OFS_RXCNT, 32'h0000_0001);
    wait_idle();
    chk({28'h0000000, cap[3:0]}, 32'h0000_0009);
    rdchk(OFS_RXCNT, ZERO_RST);
    chk(32'(t_last - t_prev), 32'h0000_0078);
    // combined mode: one queued word under the transmit count
    apb(1'b1, OFS_CTRL0, 32'h1980_0003);
    apb(1'b1, OFS_TXCNT, 32'h0000_0001);
    apb(1'b1, OFS_DATA, 32'h0000_0003);
    wait_idle();
    chk({28'h0000000, cap[3:0]}, 32'h0000_0003);
    rdchk(OFS_TXCNT, ZERO_RST);
    // two stored words plus seven dummies overflow the receive store once
    apb(1'b1, OFS_CTRL0, 32'h1900_0003);
    apb(1'b1, OFS_RXCNT, 32'h0000_0007);
    repeat (100) @(posedge pclk);
    wait_idle();
    rdchk(OFS_RAW, 32'h0000_0007);
    apb(1'b1, OFS_ICLR, 32'h0000_0001);
    rdchk(OFS_RAW, 32'h0000_0006);
    // idle level high while deselected
    apb(1'b1, OFS_CTRL0, 32'h1C00_0043);
    repeat (2) @(negedge pclk);
    chk({31'h00000000, link.sclk}, 32'h0000_0001);
    // three-wire format leaves the data line released while idle
    apb(1'b1, OFS_CTRL0, 32'h1C40_0003);
    @(negedge pclk);
    chk({30'h0000_0000, link.cs_n, link.mosi_oe_n}, 32'h0000_0003);
    // unmapped offset answers with an error and zero data
    rdchk(12'h040, ZERO_RST);
    chk({31'h00000000, er}, 32'h0000_0001);
    // second reset with the engine idle brings the map back
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_CTRL0, CTRL0_RST);
    rdchk(OFS_STAT, STAT_RST);
    final_report();
  end
endmodule // spirm_top_tb
`default_nettype wire
